/* File: pkg/rrs_regs.svh */
/*
  Constants for the remote recipe select encoder: field positions, timing and command framing.
  Assumes a 25 MHz system clock and an 8N1 serial line toward the controller.
*/
// Function
// - BCD mode reads eight inputs as two digits
// - Binary mode reads seven inputs as number
// - Discrete mode maps each input to one recipe
// - Two method inputs choose encoding, both on unused
// - Unknown recipe keeps previous selection in controller
// - Qualified code sends one recipe select command
// - Completion relay pulses after each command sent
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH
`define RRS_CLK_HZ 25000000
`define RRS_QUAL_MS 200
`define RRS_QUAL_CYC ((`RRS_QUAL_MS * (`RRS_CLK_HZ / 1000)) + 1)
`define RRS_RELAY_MS 200
`define RRS_RELAY_CYC (`RRS_RELAY_MS * (`RRS_CLK_HZ / 1000))
`define RRS_BAUD 9600
`define RRS_BIT_CYC (`RRS_CLK_HZ / `RRS_BAUD)
`define RRS_CMD_LEAD 8'h52
`define RRS_CMD_TERM 8'h0d
`define RRS_BIN_MAX 7'h63
`define RRS_DISC_N 10
`define RRS_SEL_W 10
`endif

/* File: pkg/rrs_pkg.sv */
/*
  Types for the remote recipe select encoder.
  Assumes rrs_regs.svh supplies the numeric constants.
*/
package rrs_pkg;
  typedef enum logic [1:0] {
    RRS_M_DISC = 2'b00,
    RRS_M_BCD = 2'b01,
    RRS_M_BIN = 2'b10,
    RRS_M_NONE = 2'b11
  } rrs_method_e;
  typedef enum logic [1:0] {
    RRS_IDLE = 2'b00,
    RRS_HOLD = 2'b01,
    RRS_WAIT0 = 2'b11,
    RRS_SEND = 2'b10
  } rrs_state_e;
endpackage : rrs_pkg

/* File: pkg/rrs_tx_if.sv */
/*
  Byte hand-off between the command sequencer and the serial transmitter.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface rrs_tx_if;
  logic valid;
  logic [7:0] data;
  logic ready;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rrs_tx_if

/* File: core/rrs_uart_tx.sv */
/*
  8N1 serial transmitter for the recipe select command.
  Assumes a synchronous active-low reset and a clock enable that freezes all state.
*/
`timescale 1ns/1ps
`include "rrs_regs.svh"
module rrs_uart_tx #(
  parameter int BIT_CYC = `RRS_BIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Byte in
  rrs_tx_if.snk tx,
  // Line out
  output logic txd_out
);
  // Refuse divider values that the 16-bit divider counter cannot hold
  if (BIT_CYC < 2 || BIT_CYC > 65536) begin : g_bad_bit_cyc
    $error("BIT_CYC out of range");
  end
  logic [15:0] div_q;
  logic [3:0] bit_q;
  logic [9:0] sh_q;
  logic busy_q;
  assign tx.ready = !busy_q;
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      busy_q <= 1'b0;
      div_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 10'h3ff;
      txd_out <= 1'b1;
    end else if (clk_en_in) begin
      if (!busy_q) begin
        txd_out <= 1'b1;
        if (tx.valid) begin
          busy_q <= 1'b1;
          sh_q <= {1'b1, tx.data, 1'b0};
          div_q <= 16'h0000;
          bit_q <= 4'h0;
        end
      end else begin
        txd_out <= sh_q[0];
        if (div_q == 16'(BIT_CYC - 1)) begin
          div_q <= 16'h0000;
          sh_q <= {1'b1, sh_q[9:1]};
          if (bit_q == 4'h9) begin
            busy_q <= 1'b0;
          end
          bit_q <= bit_q + 4'h1;
        end else begin
          div_q <= div_q + 16'h0001;
        end
      end
    end
  end
endmodule : rrs_uart_tx

/* File: core/rrs_encoder.sv */
/*
  Remote recipe select encoder: qualifies plant selection inputs, decodes them, sends one
  recipe select command over serial and pulses the completion relay.
  Assumes selection and method inputs are asynchronous plant levels.
*/
`timescale 1ns/1ps
`include "rrs_regs.svh"
module rrs_encoder #(
  parameter int QUAL_CYC = `RRS_QUAL_CYC,
  parameter int RELAY_CYC = `RRS_RELAY_CYC,
  parameter int BIT_CYC = `RRS_BIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Plant inputs
  input wire logic [`RRS_SEL_W-1:0] sel_in,
  input wire logic method_a_in,
  input wire logic method_b_in,
  // Outputs
  output logic txd_out,
  output logic completion_relay_output_out
);
  // Both timers are 24 bits wide; refuse counts they cannot hold
  if (QUAL_CYC < 2 || RELAY_CYC < 1 || QUAL_CYC >= 2 ** 24 || RELAY_CYC >= 2 ** 24) begin : g_bad_timing
    $error("bad timing parameters");
  end

  logic [`RRS_SEL_W+1:0] s1_q, s2_q;
  logic [23:0] cnt_q;
  logic [23:0] rly_q;
  logic [7:0] rec_q;
  logic [1:0] idx_q;
  logic relay_q;
  logic pend_q;
  rrs_pkg::rrs_state_e st_q;
  rrs_tx_if txb ();

  // Two-stage synchroniser on every plant input
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en_in) begin
      s1_q <= {method_b_in, method_a_in, sel_in};
      s2_q <= s1_q;
    end
  end

  wire logic [`RRS_SEL_W-1:0] sel = s2_q[`RRS_SEL_W-1:0];
  wire rrs_pkg::rrs_method_e meth = rrs_pkg::rrs_method_e'({s2_q[`RRS_SEL_W+1], s2_q[`RRS_SEL_W]});

  // Decode to recipe number; zero means nothing valid
  function automatic logic [7:0] decode(input rrs_pkg::rrs_method_e m, input logic [`RRS_SEL_W-1:0] s);
    logic [7:0] r;
    logic [3:0] cnt;
    r = 8'h00;
    cnt = 4'h0;
    unique case (m)
      rrs_pkg::RRS_M_BCD: begin
        if (s[3:0] <= 4'h9 && s[7:4] <= 4'h9 && s[9:8] == 2'b00) begin
          r = ({4'h0, s[7:4]} * 8'h0a) + {4'h0, s[3:0]};
        end
      end
      rrs_pkg::RRS_M_BIN: begin
        if (s[9:7] == 3'h0 && s[6:0] <= `RRS_BIN_MAX) begin
          r = {1'b0, s[6:0]};
        end
      end
      rrs_pkg::RRS_M_DISC: begin
        for (int i = 0; i < `RRS_DISC_N; i++) begin
          if (s[i]) begin
            cnt = cnt + 4'h1;
            r = 8'(i + 1);
          end
        end
        if (cnt != 4'h1) begin
          r = 8'h00;
        end
      end
      rrs_pkg::RRS_M_NONE: r = 8'h00;
    endcase
    return r;
  endfunction : decode

  wire logic [7:0] cur_rec = decode(meth, sel);

  // Excursion sequencer: idle at zero, hold a stable code, wait for zero, then send
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      st_q <= rrs_pkg::RRS_IDLE;
      cnt_q <= 24'h000000;
      rec_q <= 8'h00;
      idx_q <= 2'h0;
    end else if (clk_en_in) begin
      unique case (st_q)
        rrs_pkg::RRS_IDLE: begin
          cnt_q <= 24'h000000;
          if (sel != '0) begin
            st_q <= rrs_pkg::RRS_HOLD;
            rec_q <= cur_rec;
          end
        end
        rrs_pkg::RRS_HOLD: begin
          if (sel == '0) begin
            st_q <= rrs_pkg::RRS_IDLE;
          end else if (cur_rec != rec_q) begin
            rec_q <= cur_rec;
            cnt_q <= 24'h000000;
          end else if (cnt_q >= 24'(QUAL_CYC - 1)) begin
            st_q <= rrs_pkg::RRS_WAIT0;
          end else begin
            cnt_q <= cnt_q + 24'h000001;
          end
        end
        rrs_pkg::RRS_WAIT0: begin
          if (sel == '0) begin
            idx_q <= 2'h0;
            st_q <= (rec_q != 8'h00) ? rrs_pkg::RRS_SEND : rrs_pkg::RRS_IDLE;
          end
        end
        rrs_pkg::RRS_SEND: begin
          if (txb.ready) begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == 2'h2) begin
              st_q <= rrs_pkg::RRS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Command bytes: lead, recipe number, terminator
  always_comb begin
    txb.valid = (st_q == rrs_pkg::RRS_SEND);
    unique case (idx_q)
      2'h0: txb.data = `RRS_CMD_LEAD;
      2'h1: txb.data = rec_q;
      default: txb.data = `RRS_CMD_TERM;
    endcase
  end

  wire logic cmd_done = (st_q == rrs_pkg::RRS_SEND) && txb.ready && (idx_q == 2'h2);
  // Terminator has left the line once the transmitter is ready again after the last hand-off
  wire logic sent_done = pend_q && txb.ready;

  // Relay waits until the whole command is on the wire, so a start it gates finds the new recipe
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pend_q <= 1'b0;
      relay_q <= 1'b0;
      rly_q <= 24'h000000;
    end else if (clk_en_in) begin
      if (cmd_done) begin
        pend_q <= 1'b1;
      end else if (sent_done) begin
        pend_q <= 1'b0;
      end
      if (sent_done) begin
        relay_q <= 1'b1;
        rly_q <= 24'(RELAY_CYC - 1);
      end else if (rly_q != 24'h000000) begin
        rly_q <= rly_q - 24'h000001;
      end else begin
        relay_q <= 1'b0;
      end
    end
  end
  assign completion_relay_output_out = relay_q;

  rrs_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .tx(txb),
    .txd_out(txd_out)
  );

  a_short_hold_drop: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && st_q == rrs_pkg::RRS_HOLD && sel == '0) |=> st_q == rrs_pkg::RRS_IDLE)
    else $error("short excursion not dropped");
  a_unused_no_send: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (st_q == rrs_pkg::RRS_SEND) |-> rec_q != 8'h00)
    else $error("send with no recipe");
  a_bcd_range_ok: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (meth == rrs_pkg::RRS_M_BCD) |-> cur_rec <= 8'h63)
    else $error("bcd recipe out of range");
  a_bcd_digit_rej: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (meth == rrs_pkg::RRS_M_BCD && sel[3:0] > 4'h9) |-> cur_rec == 8'h00)
    else $error("bad bcd digit accepted");
  a_bin_range_rej: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (meth == rrs_pkg::RRS_M_BIN && sel[6:0] > 7'h63) |-> cur_rec == 8'h00)
    else $error("binary above 99 accepted");
  a_disc_onehot: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (meth == rrs_pkg::RRS_M_DISC && cur_rec != 8'h00) |-> $onehot(sel) && cur_rec <= 8'h0a)
    else $error("discrete decode wrong");
  a_disc_multi_rej: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (meth == rrs_pkg::RRS_M_DISC && !$onehot(sel)) |-> cur_rec == 8'h00)
    else $error("discrete code not one-hot accepted");
  a_qual_time: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (st_q == rrs_pkg::RRS_WAIT0 && $past(st_q) == rrs_pkg::RRS_HOLD) |-> cnt_q >= 24'(QUAL_CYC - 1))
    else $error("qualified too early");
  a_zero_starts_send: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && st_q == rrs_pkg::RRS_WAIT0 && sel == '0 && rec_q != 8'h00) |=> st_q == rrs_pkg::RRS_SEND)
    else $error("qualified code not sent");
  a_relay_after_cmd: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && sent_done) |=> completion_relay_output_out)
    else $error("relay not raised");
  a_relay_waits_tx: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && !completion_relay_output_out && !sent_done) |=> !completion_relay_output_out)
    else $error("relay raised before command sent");
  a_relay_stands: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && completion_relay_output_out && rly_q != 24'h000000) |=> completion_relay_output_out)
    else $error("relay pulse cut short");
  a_send_idle_after: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in && cmd_done) |=> st_q == rrs_pkg::RRS_IDLE)
    else $error("extra command bytes");
endmodule : rrs_encoder

/* File: sim/rrs_ctrl_model.sv */
/*
  Behavioural controller: receives recipe select frames on the serial line.
  Assumes 8N1 framing, idle high, BIT_CYC clocks per bit.
*/
`timescale 1ns/1ps
`include "rrs_regs.svh"
module rrs_ctrl_model #(
  parameter int BIT_CYC = 4,
  parameter int NUM_RECIPES = 99
) (
  // Line in
  input wire logic sys_clk_in,
  input wire logic rxd_in,
  // Start in
  input wire logic start_in,
  // Status out
  output logic [7:0] cmd_count_out,
  output logic [7:0] recipe_out,
  output logic [7:0] start_count_out,
  output logic [7:0] start_recipe_out
);
  logic [7:0] rx_byte;
  logic [7:0] frame [0:2];
  logic start_q = 1'b0;
  logic [7:0] starts = 8'h00;
  logic [7:0] start_rec = 8'h00;
  // Relay wired straight to start; a mix takes the recipe in effect at the leading edge
  always @(posedge sys_clk_in) begin
    start_q <= start_in;
    if (start_in === 1'b1 && start_q !== 1'b1) begin
      starts <= starts + 8'h01;
      start_rec <= recipe_out;
    end
  end
  assign start_count_out = starts;
  assign start_recipe_out = start_rec;
  initial begin
    cmd_count_out = 8'h00;
    recipe_out = 8'h00;
    forever begin
      for (int n = 0; n < 3; n++) begin
        @(negedge rxd_in);
        repeat (BIT_CYC / 2) @(posedge sys_clk_in);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge sys_clk_in);
          rx_byte[i] = rxd_in;
        end
        repeat (BIT_CYC) @(posedge sys_clk_in);
        frame[n] = rx_byte;
      end
      if (frame[0] === `RRS_CMD_LEAD && frame[2] === `RRS_CMD_TERM) begin
        cmd_count_out = cmd_count_out + 8'h01;
        // Unknown recipe leaves the previous one in effect
        if (frame[1] >= 8'h01 && frame[1] <= NUM_RECIPES) recipe_out = frame[1];
      end
    end
  end
endmodule : rrs_ctrl_model

/* File: sim/testbench.sv */
/*
  Self-checking bench for the recipe select encoder.
  Assumes shortened counts: qualify 20, relay 10, bit 4 cycles.
*/
`timescale 1ns/1ps
module testbench;
  localparam int RELAY = 10;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [9:0] sel_in = 10'h000;
  logic method_a_in = 1'b0;
  logic method_b_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [7:0] start_count;
  logic [7:0] start_recipe;
  logic txd_out;
  logic relay;
  logic relay_q = 1'b0;
  logic [7:0] relay_rises = 8'h00;
  logic [7:0] relay_len = 8'h00;
  logic [7:0] cmd_count;
  logic [7:0] recipe;
  int num_errors = 0;
  int checked = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    relay_q <= relay;
    if (relay === 1'b1 && relay_q !== 1'b1) relay_rises <= relay_rises + 8'h01;
    if (relay === 1'b1) relay_len <= (relay_q === 1'b1 ? relay_len : 8'h00) + 8'h01;
  end
  rrs_encoder #(.QUAL_CYC(20), .RELAY_CYC(RELAY), .BIT_CYC(4)) rrs_encoder_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .sel_in(sel_in),
    .method_a_in(method_a_in), .method_b_in(method_b_in), .txd_out(txd_out),
    .completion_relay_output_out(relay));
  rrs_ctrl_model #(.BIT_CYC(4)) rrs_ctrl_model_inst (
    .sys_clk_in(sys_clk_in), .rxd_in(txd_out), .start_in(relay), .cmd_count_out(cmd_count),
    .recipe_out(recipe), .start_count_out(start_count), .start_recipe_out(start_recipe));
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask : check
  // Exp of zero means the excursion must be dropped
  task automatic run_sel(input string name, input logic a, input logic b, input logic [9:0] code,
                         input int hold, input logic [7:0] exp);
    logic [7:0] cnt0;
    logic [7:0] rise0;
    logic [7:0] rec0;
    logic [7:0] st0;
    logic hit;
    int k;
    cnt0 = cmd_count;
    rise0 = relay_rises;
    rec0 = recipe;
    st0 = start_count;
    hit = (exp != 8'h00);
    k = 0;
    @(posedge sys_clk_in);
    method_a_in <= a;
    method_b_in <= b;
    repeat (4) @(posedge sys_clk_in);
    sel_in <= code;
    repeat (hold) @(posedge sys_clk_in);
    sel_in <= 10'h000;
    while (cmd_count === cnt0 && k < 300) begin
      @(posedge sys_clk_in);
      k++;
    end
    repeat (30) @(posedge sys_clk_in);
    check("commands", cmd_count, cnt0 + {7'h00, hit});
    check("recipe", recipe, hit ? exp : rec0);
    check("relay pulses", relay_rises, rise0 + {7'h00, hit});
    if (hit) check("relay length", relay_len, 8'(RELAY));
    check("starts", start_count, st0 + {7'h00, hit});
    if (hit) check("recipe at start", start_recipe, exp);
    $display("test %s done", name);
  endtask : run_sel
  task results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    #1600000;
    num_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge sys_clk_in);
    check("reset line", {7'h00, txd_out}, 8'h01);
    check("reset relay", {7'h00, relay}, 8'h00);
    reset_n_in <= 1'b1;
    run_sel("bcd_99", 1'b1, 1'b0, 10'h099, 30, 8'd99);
    run_sel("bcd_01", 1'b1, 1'b0, 10'h001, 30, 8'd1);
    run_sel("bin_99", 1'b0, 1'b1, 10'h063, 30, 8'd99);
    run_sel("bin_37", 1'b0, 1'b1, 10'h025, 30, 8'd37);
    for (int i = 0; i < 10; i++) begin
      run_sel("discrete", 1'b0, 1'b0, 10'h001 << i, 30, 8'(i + 1));
    end
    run_sel("zero", 1'b1, 1'b0, 10'h000, 30, 8'h00);
    run_sel("unused", 1'b1, 1'b1, 10'h005, 30, 8'h00);
    run_sel("short", 1'b1, 1'b0, 10'h012, 10, 8'h00);
    run_sel("bcd_digit", 1'b1, 1'b0, 10'h01a, 30, 8'h00);
    run_sel("bcd_high", 1'b1, 1'b0, 10'h105, 30, 8'h00);
    run_sel("bin_100", 1'b0, 1'b1, 10'h064, 30, 8'h00);
    run_sel("disc_two", 1'b0, 1'b0, 10'h003, 30, 8'h00);
    clk_en_in <= 1'b0;
    run_sel("frozen", 1'b1, 1'b0, 10'h025, 30, 8'h00);
    clk_en_in <= 1'b1;
    run_sel("after_refusals", 1'b1, 1'b0, 10'h042, 30, 8'd42);
    results();
  end
endmodule : testbench
